// [core/msp_map.vh]
// Constants for the meter serial register port
`ifndef MSP_MAP_VH
`define MSP_MAP_VH
`define MSP_ID_READ       8'h58
`define MSP_ID_WRITE      8'hA8
`define MSP_FF_BYTE       8'hFF
`define MSP_FF_RESET_CNT  3'h6
`define MSP_FRAME_LAST    6'h2F
`define MSP_BIT_LAST      3'h7
`define MSP_B_ID          3'h0
`define MSP_B_ADDR        3'h1
`define MSP_B_DATA_H      3'h2
`define MSP_B_DATA_M      3'h3
`define MSP_B_DATA_L      3'h4
`define MSP_B_CSUM        3'h5
`define MSP_SCLK_MAX_KHZ  900
`define MSP_SYS_KHZ       25000
`define MSP_SYNC_FILL     2'h2
`endif

// [core/msp_sync.v]
// Two-stage synchroniser bank for pin inputs
`timescale 1ns/1ps
module msp_sync #(
	parameter W = 4
) (
	// Clock and reset
	input  wire         clk_sys,
	input  wire         reset_n,
	// Asynchronous and synchronised levels
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);
	reg [W-1:0] meta_q;

	// First stage feeds only the second stage
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			meta_q   <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// [core/msp_txsr.v]
// Outgoing shift register, most significant bit first
`timescale 1ns/1ps
module msp_txsr #(
	parameter W = 32
) (
	// Clock and reset
	input  wire         clk_sys,
	input  wire         reset_n,
	// Control
	input  wire         load,
	input  wire [W-1:0] load_val,
	input  wire         shift,
	// Next bit to present
	output wire         msb
);
	reg [W-1:0] sr_q;

	assign msb = sr_q[W-1];

	// Load wins over shift; zeros fill from the bottom
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sr_q <= {W{1'b0}};
		end else if (load) begin
			sr_q <= load_val;
		end else if (shift) begin
			sr_q <= {sr_q[W-2:0], 1'b0};
		end
	end
endmodule

// [core/msp_port.v]
// Serial register port slave: mode 1, 48-clock frames with checksum
`timescale 1ns/1ps
`include "msp_map.vh"
module msp_port #(
	parameter DATA_W = 24,
	parameter ADDR_W = 8
) (
	// Clock and reset
	input  wire              clk_sys,
	input  wire              reset_n,
	// Interface select and serial pins
	input  wire              sel_pin,
	input  wire              sclk_pin,
	input  wire              chip_select_or_addr_bit_pin,
	input  wire              sdi_pin,
	output reg               sdo_o,
	output reg               sdo_oe_n,
	// Register side
	output reg  [ADDR_W-1:0] reg_addr_q,
	output reg               reg_rd_q,
	input  wire [DATA_W-1:0] reg_rd_data,
	output reg               reg_wr_q,
	output reg  [DATA_W-1:0] reg_wdata_q,
	// Status
	output reg               uart_mode_q,
	output reg               frame_busy_q,
	output reg               frame_err_q,
	output reg               soft_rst_q
);
	localparam TX_W = DATA_W + 8;

	// Synchronised pins
	wire [3:0] pins_s;
	wire       sel_s;
	wire       sclk_s;
	wire       cs_n_s;
	wire       sdi_s;

	// Edge detection and framing state
	reg        sclk_d_q;
	wire       sclk_rise;
	wire       sclk_fall;
	reg  [5:0] bit_cnt_q;
	reg  [6:0] rx_sr_q;
	wire [7:0] rx_byte;
	wire       byte_done;
	wire [2:0] byte_idx;
	reg  [7:0] id_q;
	reg  [7:0] wbyte_h_q;
	reg  [7:0] wbyte_m_q;
	reg  [7:0] wbyte_l_q;
	reg  [2:0] ff_cnt_q;
	reg        rd_wait_q;
	reg        tx_on_q;
	wire       link_off;
	wire       ff_reset;
	wire       link_clr;
	wire       frame_end;
	reg  [1:0] warm_q;
	wire       warm;

	// Outgoing shifter
	wire            tx_msb;
	wire            tx_load;
	wire [TX_W-1:0] tx_val;
	wire [7:0]      rd_csum;

	// Inverted low byte of the five-byte sum
	// Sum is kept wide so no carry is lost before the low byte is taken
	function [7:0] msp_csum;
		input [7:0] b0;
		input [7:0] b1;
		input [7:0] b2;
		input [7:0] b3;
		input [7:0] b4;
		reg   [10:0] sum;
		begin
			sum = {3'h0, b0} + {3'h0, b1} + {3'h0, b2} + {3'h0, b3}
				+ {3'h0, b4};
			msp_csum = ~sum[7:0];
		end
	endfunction

	// All pins cross into the system clock first
	// Every pin pays two cycles of latency, well inside a half serial period
	msp_sync #(
		.W (4)
	) u_sync (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.async_in ({sel_pin, sclk_pin, chip_select_or_addr_bit_pin, sdi_pin}),
		.sync_out (pins_s)
	);

	assign sel_s  = pins_s[3];
	assign sclk_s = pins_s[2];
	assign cs_n_s = pins_s[1];
	assign sdi_s  = pins_s[0];

	// Pins count as settled once both sync stages have filled; before that
	// the reset level of the bank would pass for the other serial method.
	assign warm = (warm_q == `MSP_SYNC_FILL);

	// Fill counter stops at its end value and stays there until reset
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			warm_q <= 2'h0;
		end else if (!warm) begin
			warm_q <= warm_q + 2'h1;
		end
	end

	// Clock idles low; edges found from the synchronised level
	assign sclk_rise = sclk_s & ~sclk_d_q;
	assign sclk_fall = ~sclk_s & sclk_d_q;

	// Deselected or in the other serial mode: link is parked; a frame cut
	// short by deselect is dropped, and the next select starts a new one
	assign link_off = ~warm | ~sel_s | cs_n_s;

	// One clear for deselect and soft reset, one decode for the last fall
	assign link_clr  = link_off | ff_reset;
	assign frame_end = sclk_fall & (bit_cnt_q == `MSP_FRAME_LAST);

	// Byte assembly on the falling edge, MSB first; sdi moves only on rises,
	// so the synchronised level at the detected fall is the sampled bit
	assign rx_byte   = {rx_sr_q, sdi_s};
	assign byte_done = sclk_fall & ~link_off & (bit_cnt_q[2:0] == `MSP_BIT_LAST);
	assign byte_idx  = bit_cnt_q[5:3];

	// Six 0xFF bytes in a row clear the serial logic, which is the host's
	// only way back into step after a torn frame in three-wire form
	assign ff_reset = byte_done & (rx_byte == `MSP_FF_BYTE)
		& (ff_cnt_q == (`MSP_FF_RESET_CNT - 3'h1));

	// Read payload: data high first, then own checksum
	// Unused upper register bits arrive as zeros from the register side
	assign rd_csum = msp_csum(`MSP_ID_READ, reg_addr_q, reg_rd_data[23:16],
		reg_rd_data[15:8], reg_rd_data[7:0]);
	assign tx_val  = {reg_rd_data, rd_csum};
	assign tx_load = rd_wait_q;

	msp_txsr #(
		.W (TX_W)
	) u_txsr (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.load     (tx_load),
		.load_val (tx_val),
		.shift    (sclk_rise & tx_on_q & ~link_off),
		.msb      (tx_msb)
	);

	// Edge detector history; its reset level matches the idle low clock,
	// so no false edge follows reset
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sclk_d_q <= 1'b0;
		end else begin
			sclk_d_q <= sclk_s;
		end
	end

	// Mode indication follows the select pin
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			uart_mode_q <= 1'b0;
		end else begin
			uart_mode_q <= warm & ~sel_s;
		end
	end

	// Bit counter and receive shifter; a stub frame keeps its count until
	// deselect or soft reset brings the host back into step
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt_q <= 6'h00;
			rx_sr_q   <= 7'h00;
		end else if (link_clr) begin
			bit_cnt_q <= 6'h00;
			rx_sr_q   <= 7'h00;
		end else if (sclk_fall) begin
			rx_sr_q <= rx_byte[6:0];
			if (bit_cnt_q == `MSP_FRAME_LAST) begin
				bit_cnt_q <= 6'h00;
			end else begin
				bit_cnt_q <= bit_cnt_q + 6'h01;
			end
		end
	end

	// Frame activity for the outside world
	// Busy follows the count, so it drops two cycles after the last fall is seen
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			frame_busy_q <= 1'b0;
		end else begin
			frame_busy_q <= (bit_cnt_q != 6'h00);
		end
	end

	// Consecutive 0xFF counter; any other byte restarts it
	// Data bytes of 0xFF count too, and the count runs across frame borders
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ff_cnt_q   <= 3'h0;
			soft_rst_q <= 1'b0;
		end else begin
			soft_rst_q <= ff_reset;
			if (!sel_s || ff_reset) begin
				ff_cnt_q <= 3'h0;
			end else if (byte_done) begin
				if (rx_byte == `MSP_FF_BYTE) begin
					ff_cnt_q <= ff_cnt_q + 3'h1;
				end else begin
					ff_cnt_q <= 3'h0;
				end
			end
		end
	end

	// Captured bytes of the frame in progress
	// The checksum byte is not stored; it is judged as it completes
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			id_q       <= 8'h00;
			reg_addr_q <= {ADDR_W{1'b0}};
			wbyte_h_q  <= 8'h00;
			wbyte_m_q  <= 8'h00;
			wbyte_l_q  <= 8'h00;
		end else if (byte_done) begin
			case (byte_idx)
				`MSP_B_ID: begin
					id_q <= rx_byte;
				end
				`MSP_B_ADDR: begin
					reg_addr_q <= rx_byte[ADDR_W-1:0];
				end
				`MSP_B_DATA_H: begin
					wbyte_h_q <= rx_byte;
				end
				`MSP_B_DATA_M: begin
					wbyte_m_q <= rx_byte;
				end
				`MSP_B_DATA_L: begin
					wbyte_l_q <= rx_byte;
				end
				default: begin
					id_q <= id_q;
				end
			endcase
		end
	end

	// Read fetch: strobe after the address, sample data one cycle later
	// The shifter loads in the cycle after the strobe, long before the
	// first data rise, so the register side needs no wait state
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			reg_rd_q  <= 1'b0;
			rd_wait_q <= 1'b0;
		end else begin
			reg_rd_q  <= byte_done && !ff_reset && (byte_idx == `MSP_B_ADDR)
				&& (id_q == `MSP_ID_READ);
			rd_wait_q <= reg_rd_q;
		end
	end

	// Write commit only when identifier and checksum both agree
	// A bad write leaves the register side untouched and only flags the frame
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			reg_wr_q    <= 1'b0;
			reg_wdata_q <= {DATA_W{1'b0}};
			frame_err_q <= 1'b0;
		end else begin
			reg_wr_q    <= 1'b0;
			frame_err_q <= 1'b0;
			if (byte_done && !ff_reset && (byte_idx == `MSP_B_CSUM)) begin
				if ((id_q == `MSP_ID_WRITE) && (rx_byte == msp_csum(id_q,
					reg_addr_q, wbyte_h_q, wbyte_m_q, wbyte_l_q))) begin
					reg_wr_q    <= 1'b1;
					reg_wdata_q <= {wbyte_h_q, wbyte_m_q, wbyte_l_q};
				end else if (id_q != `MSP_ID_READ) begin
					frame_err_q <= 1'b1;
				end
			end
		end
	end

	// Transmit window: opens once data is loaded, closes with the frame
	// Only a read id ever loads the shifter, so writes leave the pin floating
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			tx_on_q <= 1'b0;
		end else if (link_clr) begin
			tx_on_q <= 1'b0;
		end else if (frame_end) begin
			tx_on_q <= 1'b0;
		end else if (tx_load) begin
			tx_on_q <= 1'b1;
		end
	end

	// Output pin: bit changes only on a rising edge, so it holds while high;
	// the data half period leaves about a dozen system clocks of margin at
	// the top serial rate, which is why the fetch may take two cycles.
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sdo_o    <= 1'b0;
			sdo_oe_n <= 1'b1;
		end else if (link_clr) begin
			sdo_o    <= 1'b0;
			sdo_oe_n <= 1'b1;
		end else if (frame_end) begin
			sdo_oe_n <= 1'b1;
		end else if (sclk_rise && tx_on_q) begin
			sdo_o    <= tx_msb;
			sdo_oe_n <= 1'b0;
		end
	end
endmodule

// [test/msp_port_properties.sv]
// Pin-level checks for the serial register port
`timescale 1ns/1ps
module msp_port_properties (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Serial pins
	input wire logic sclk_pin,
	input wire logic chip_select_or_addr_bit_pin,
	input wire logic sdo_o,
	input wire logic sdo_oe_n,
	// Strobes and status
	input wire logic reg_rd_q,
	input wire logic reg_wr_q,
	input wire logic uart_mode_q,
	input wire logic frame_busy_q,
	input wire logic frame_err_q,
	input wire logic soft_rst_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// Deselect held long enough to pass the synchroniser
	sequence cs_idle;
		chip_select_or_addr_bit_pin [*5];
	endsequence
	sequence bit_moves;
		!sdo_oe_n && $changed(sdo_o);
	endsequence
	a_uart_float: assert property (uart_mode_q [*2] |-> sdo_oe_n)
		else $error("sdo driven");
	a_cs_release: assert property (cs_idle |-> !frame_busy_q && sdo_oe_n)
		else $error("cs ignored");
	a_rd_single: assert property (reg_rd_q |=> !reg_rd_q [*8])
		else $error("read repeated");
	a_wr_clean: assert property (reg_wr_q |=> (!reg_wr_q && !frame_err_q) [*8])
		else $error("write repeated");
	a_sdo_on_rise: assert property (bit_moves |-> $past(sclk_pin, 2) && !$past(sclk_pin, 5))
		else $error("sdo off rise");
	a_drive_start: assert property ($fell(sdo_oe_n) |-> $past(sclk_pin, 2) && frame_busy_q)
		else $error("sdo start");
	a_float_end: assert property ($rose(sdo_oe_n) |-> !$past(sclk_pin, 2))
		else $error("sdo release");
	a_soft_clear: assert property (soft_rst_q |=> !frame_busy_q && sdo_oe_n)
		else $error("soft reset");
endmodule
bind msp_port msp_port_properties i_msp_port_properties (.clk_sys, .reset_n, .sclk_pin,
	.chip_select_or_addr_bit_pin, .sdo_o, .sdo_oe_n, .reg_rd_q, .reg_wr_q, .uart_mode_q,
	.frame_busy_q, .frame_err_q, .soft_rst_q);

// [test/msp_host_model.sv]
// Host master model sending mode-1 frames
`timescale 1ns/1ps
module msp_host_model #(
	parameter HALF = 14
) (
	// System clock
	input  wire logic clk_sys,
	// Serial pins
	input  wire logic sdo_o,
	input  wire logic sdo_oe_n,
	output logic      sclk_pin,
	output logic      cs_n,
	output logic      sdi
);
	logic last_q = 1'b0;
	wire  sdo_w;
	// A released line shows the inverse of its last bit, never a held value
	always @(posedge clk_sys)
		if (!sdo_oe_n) last_q <= sdo_o;
	assign sdo_w = sdo_oe_n ? ~last_q : sdo_o;
	initial begin
		sclk_pin = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
	end
	// 14 system clocks a half period keeps the link just under 900 kHz
	task automatic frame(logic [47:0] tx, int n, logic cs_after, output logic [47:0] rx);
		rx = '0;
		cs_n <= 1'b0;
		for (int i = 47; i > 47 - n; i--) begin
			repeat (HALF) @(posedge clk_sys);
			sclk_pin <= 1'b1;
			sdi <= tx[i];
			repeat (HALF) @(posedge clk_sys);
			rx[i] = sdo_w;
			sclk_pin <= 1'b0;
		end
		repeat (HALF) @(posedge clk_sys);
		cs_n <= cs_after;
		sdi <= ~sdi;
		// Let a deselect stand before the next frame selects again
		repeat (HALF) @(posedge clk_sys);
	endtask
endmodule

// [test/msp_port_tb.sv]
// Self-checking bench for the serial register port
`timescale 1ns/1ps
module msp_port_tb;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic        sel_pin = 1'b1;
	logic [23:0] reg_rd_data = 24'h000000;
	logic [47:0] rx;
	logic [7:0]  rd_a, wr_a;
	logic [23:0] wr_d;
	int          num_errors = 0, cmp_count = 0, rd_n = 0, wr_n = 0, err_n = 0, sr_n = 0;
	wire         sclk_pin, cs_n, sdi, sdo_o, sdo_oe_n, reg_rd_q, reg_wr_q;
	wire         uart_mode_q, frame_busy_q, frame_err_q, soft_rst_q;
	wire [7:0]   reg_addr_q;
	wire [23:0]  reg_wdata_q;

	initial forever #20 clk_sys = ~clk_sys;

	msp_port i_msp_port (.clk_sys, .reset_n, .sel_pin, .sclk_pin,
		.chip_select_or_addr_bit_pin(cs_n), .sdi_pin(sdi), .sdo_o, .sdo_oe_n, .reg_addr_q,
		.reg_rd_q, .reg_rd_data, .reg_wr_q, .reg_wdata_q, .uart_mode_q, .frame_busy_q,
		.frame_err_q, .soft_rst_q);
	msp_host_model i_msp_host_model (.clk_sys, .sdo_o, .sdo_oe_n, .sclk_pin, .cs_n, .sdi);

	// Tally pulses; a missed pulse shows up as a short count
	always @(posedge clk_sys) begin
		if (reg_rd_q === 1'b1) begin
			rd_n++;
			rd_a = reg_addr_q;
		end
		if (reg_wr_q === 1'b1) begin
			wr_n++;
			wr_a = reg_addr_q;
			wr_d = reg_wdata_q;
		end
		err_n += (frame_err_q === 1'b1);
		sr_n += (soft_rst_q === 1'b1);
	end

	function automatic logic [47:0] mk(logic [7:0] id, logic [7:0] a, logic [23:0] d);
		logic [7:0] s;
		s = id + a + d[23:16] + d[15:8] + d[7:0];
		return {id, a, d, ~s};
	endfunction
	task automatic chk(logic [47:0] got, logic [47:0] exp, string m);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic go(logic [47:0] tx, int n, logic cs_after);
		i_msp_host_model.frame(tx, n, cs_after, rx);
	endtask
	task automatic rd(logic [7:0] a, logic [23:0] d, logic c);
		logic [47:0] e;
		e = mk(8'h58, a, d);
		reg_rd_data <= d;
		go({8'h58, a, 32'h00000000}, 48, c);
		chk(rx[31:0], e[31:0], "read frame");
		chk(rd_a, a, "read address");
	endtask
	task automatic summarize;
		$display("compares %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		logic [7:0]  a;
		logic [23:0] d;
		int          s;
		s = $urandom(32'hD3B5A544);
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (6) @(posedge clk_sys);
		// Reads with boundary words, alternating three- and four-wire
		for (int k = 0; k < 4; k++) begin
			d = (k == 0) ? 24'h000000 : (k == 1) ? 24'hFFFFFF : 24'($urandom);
			rd(8'($urandom), d, k[0]);
			chk(rd_n, k + 1, "read count");
		end
		$display("reads done");
		// Random writes, then a bad checksum and an unknown id
		for (int k = 0; k < 4; k++) begin
			a = 8'($urandom);
			d = 24'($urandom);
			go(mk(8'hA8, a, d), 48, k[0]);
			chk({wr_a, wr_d}, {a, d}, "write word");
		end
		go(mk(8'hA8, a, d) ^ 48'h1, 48, 1'b1);
		go(mk(8'h3C, a, d), 48, 1'b1);
		chk(wr_n, 4, "dropped write");
		chk(err_n, 2, "error pulses");
		$display("writes done");
		// A stub misaligns the bytes; six 0xFF bytes must restore order
		go(48'h0, 16, 1'b0);
		go({48{1'b1}}, 48, 1'b0);
		chk(sr_n, 1, "soft reset");
		// A read cut by deselect after its first data byte must end cleanly
		reg_rd_data <= 24'h5A3C96;
		go({8'h58, 8'h22, 32'h00000000}, 24, 1'b1);
		chk(rx[31:24], 8'h5A, "cut read");
		rd(8'h10, 24'h00A5C3, 1'b1);
		$display("soft reset done");
		// Select low hands the pins away, so no read happens
		sel_pin <= 1'b0;
		repeat (6) @(posedge clk_sys);
		chk(uart_mode_q, 1'b1, "uart mode");
		go({8'h58, 40'h0}, 48, 1'b1);
		chk(rd_n, 6, "read deselected");
		sel_pin <= 1'b1;
		repeat (6) @(posedge clk_sys);
		$display("select done");
		summarize;
	end
	// Cut a hung run short
	initial begin
		#3000000;
		num_errors++;
		$display("wrong value at %0t: timeout", $time);
		summarize;
	end
endmodule
